// [core/dcc_pkg.sv]
package dcc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PORT_W = 6;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FLAG = 8'h04;
   localparam logic [7:0] OFS_IEN = 8'h08;
   localparam logic [7:0] OFS_IRQCTL = 8'h0c;
   localparam logic [7:0] OFS_PORT = 8'h10;
   localparam logic [7:0] OFS_DIR = 8'h14;

   // field positions
   localparam int CTRL_OUT2_BIT = 7;
   localparam int CTRL_OUT1_BIT = 6;
   localparam int CTRL_INV2_BIT = 5;
   localparam int CTRL_INV1_BIT = 4;
   localparam int CTRL_SWITCH_BIT = 3;
   localparam int FLAG_BIT = 6;
   localparam int IEN_BIT = 6;
   localparam int GLOBAL_EN_BIT = 7;
   localparam int PERIPH_EN_BIT = 6;
   localparam int PIN1_IDX = 4;
   localparam int PIN2_IDX = 5;

   typedef enum logic [2:0] {
      MODE_RESET_ZERO = 3'h0,
      MODE_ONE_INDEP = 3'h1,
      MODE_TWO_INDEP = 3'h2,
      MODE_TWO_OUT = 3'h3,
      MODE_TWO_COMMON = 3'h4,
      MODE_COMMON_OUT = 3'h5,
      MODE_FOUR_MUX = 3'h6,
      MODE_OFF = 3'h7
   } dcc_mode_t;

   // input selector codes: 0..3 analog pins, 6 unused, 7 internal reference
   localparam logic [2:0] SEL_AN0 = 3'h0;
   localparam logic [2:0] SEL_AN1 = 3'h1;
   localparam logic [2:0] SEL_AN2 = 3'h2;
   localparam logic [2:0] SEL_AN3 = 3'h3;
   localparam logic [2:0] SEL_NONE = 3'h6;
   localparam logic [2:0] SEL_VREF = 3'h7;

   typedef struct packed {
      logic inv2;
      logic inv1;
      logic inSwitch;
      dcc_mode_t mode;
   } dcc_ctrl_t;

   typedef struct packed {
      logic [1:0] cmpOn;
      logic [2:0] neg1;
      logic [2:0] pos1;
      logic [2:0] neg2;
      logic [2:0] pos2;
      logic route;
   } dcc_sel_t;

   localparam dcc_ctrl_t CTRL_RESET = '{inv2: 1'b0, inv1: 1'b0, inSwitch: 1'b0, mode: MODE_OFF};
   localparam logic [5:0] DIR_RESET = 6'h3f;
endpackage

// [core/dcc_top.sv]
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - two comparators on four analog pins or reference; results readable and pin-routable
// - three-bit mode field in control bits 2..0 picks one of eight setups
// - raw result high when positive input above negative input, else low
// - result bits 7 and 6 show raw result, complemented when inversion set
// - control bits 5 and 4 invert each comparator output when set
// - mode 110: input switch moves negative inputs to AN3/AN2 or AN0/AN1
// - internal reference drives both positive inputs, only in mode 110
// - result bits are read-only; writes to them do nothing
// - routed modes drive unsynchronised results straight onto the two output pins
// - port direction bits still enable the two pins while routed
// - port data read returns zero for every analog input pin
// - flag bit 6 of flag register sets on any comparator output change
// - software write of one sets flag, write of zero clears it
// - interrupt reaches core only with all three enables; flag sets regardless
// - change during control register access may fail to set the flag
// - mismatch keeps setting flag; any control access ends the mismatch
// - comparators run in sleep; enabled interrupt wakes; control unchanged
// - reset puts mode 111, clears inversion and input switch bits
module dcc_top #(
   parameter int ADDR_W = dcc_pkg::ADDR_W,
   parameter int PORT_W = dcc_pkg::PORT_W
) (
   input wire logic sys_clk, // core clock
   input wire logic arst_n, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [ADDR_W-1:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic cmp1Raw, // comparator 1 analog result
   input wire logic cmp2Raw, // comparator 2 analog result
   input wire logic [PORT_W-1:0] portPinIn, // digital pin levels
   input wire logic [PORT_W-1:0] analogPinMask, // 1 = pin is analog input
   input wire logic [1:0] portLatchOut, // port latch bits for pins 4 and 5
   input wire logic sleepMode, // core asleep
   output logic cmp1OutPin, // pin 4 data
   output logic cmp2OutPin, // pin 5 data
   output logic cmp1OutPinOe, // pin 4 drive enable
   output logic cmp2OutPinOe, // pin 5 drive enable
   output dcc_pkg::dcc_sel_t anaSel, // analog mux and enable selects
   output logic cmpIrq, // interrupt to core
   output logic wakeReq // wake from sleep
);

   dcc_pkg::dcc_ctrl_t ctrl_reg;
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] latched_reg;
   logic flag_reg;
   logic ien_reg;
   logic globalEn_reg;
   logic periphEn_reg;
   logic [PORT_W-1:0] dir_reg;
   logic [31:0] rd_next;
   logic err_next;
   logic setupPhase;
   logic doneAcc;
   logic ctrlAcc;
   logic mismatch;
   logic [1:0] outVal;
   logic [1:0] rawGated;
   logic flagSet;
   dcc_pkg::dcc_sel_t sel_next;
   logic [7:0] addrLo;

   assign addrLo = paddr[7:0];
   assign setupPhase = psel & ~penable;
   assign doneAcc = psel & penable & pready;
   assign ctrlAcc = doneAcc & (addrLo == dcc_pkg::OFS_CTRL);

   always_comb begin
      sel_next = '{cmpOn: 2'b11, neg1: dcc_pkg::SEL_AN0, pos1: dcc_pkg::SEL_AN3,
                   neg2: dcc_pkg::SEL_AN1, pos2: dcc_pkg::SEL_AN2, route: 1'b0};
      case (ctrl_reg.mode)
         dcc_pkg::MODE_OFF: begin
            sel_next = '{cmpOn: 2'b00, neg1: dcc_pkg::SEL_NONE, pos1: dcc_pkg::SEL_NONE,
                         neg2: dcc_pkg::SEL_NONE, pos2: dcc_pkg::SEL_NONE, route: 1'b0};
         end
         dcc_pkg::MODE_RESET_ZERO: begin
            sel_next.cmpOn = 2'b00;
         end
         dcc_pkg::MODE_ONE_INDEP: begin
            sel_next.cmpOn = 2'b01;
            sel_next.neg2 = dcc_pkg::SEL_NONE;
            sel_next.pos2 = dcc_pkg::SEL_NONE;
         end
         dcc_pkg::MODE_TWO_OUT: begin
            sel_next.route = 1'b1;
         end
         dcc_pkg::MODE_TWO_COMMON: begin
            sel_next.pos1 = dcc_pkg::SEL_AN2;
         end
         dcc_pkg::MODE_COMMON_OUT: begin
            sel_next.pos1 = dcc_pkg::SEL_AN2;
            sel_next.route = 1'b1;
         end
         dcc_pkg::MODE_FOUR_MUX: begin
            sel_next.pos1 = dcc_pkg::SEL_VREF;
            sel_next.pos2 = dcc_pkg::SEL_VREF;
            sel_next.neg1 = ctrl_reg.inSwitch ? dcc_pkg::SEL_AN3 : dcc_pkg::SEL_AN0;
            sel_next.neg2 = ctrl_reg.inSwitch ? dcc_pkg::SEL_AN2 : dcc_pkg::SEL_AN1;
         end
         default: begin
            sel_next.cmpOn = 2'b11;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         anaSel <= '{cmpOn: 2'b00, neg1: dcc_pkg::SEL_NONE, pos1: dcc_pkg::SEL_NONE,
                     neg2: dcc_pkg::SEL_NONE, pos2: dcc_pkg::SEL_NONE, route: 1'b0};
      end else begin
         anaSel <= sel_next;
      end
   end

   assign rawGated = {cmp2Raw & anaSel.cmpOn[1], cmp1Raw & anaSel.cmpOn[0]};

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= 2'b00;
         sync2_reg <= 2'b00;
      end else begin
         sync1_reg <= rawGated;
         sync2_reg <= sync1_reg;
      end
   end

   assign outVal = sync2_reg ^ {ctrl_reg.inv2, ctrl_reg.inv1};

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         latched_reg <= 2'b00;
      end else if (ctrlAcc) begin
         latched_reg <= sync2_reg;
      end
   end

   assign mismatch = sync2_reg != latched_reg;
   assign flagSet = mismatch & ~ctrlAcc;

   // only reset or software touches control
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= dcc_pkg::CTRL_RESET;
      end else if (ctrlAcc && pwrite) begin
         ctrl_reg <= dcc_pkg::dcc_ctrl_t'(pwdata[5:0]);
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag_reg <= 1'b0;
      end else if (flagSet) begin
         flag_reg <= 1'b1;
      end else if (doneAcc && pwrite && addrLo == dcc_pkg::OFS_FLAG) begin
         flag_reg <= pwdata[dcc_pkg::FLAG_BIT];
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ien_reg <= 1'b0;
         globalEn_reg <= 1'b0;
         periphEn_reg <= 1'b0;
         dir_reg <= dcc_pkg::DIR_RESET;
      end else if (doneAcc && pwrite) begin
         if (addrLo == dcc_pkg::OFS_IEN) begin
            ien_reg <= pwdata[dcc_pkg::IEN_BIT];
         end
         if (addrLo == dcc_pkg::OFS_IRQCTL) begin
            globalEn_reg <= pwdata[dcc_pkg::GLOBAL_EN_BIT];
            periphEn_reg <= pwdata[dcc_pkg::PERIPH_EN_BIT];
         end
         if (addrLo == dcc_pkg::OFS_DIR) begin
            dir_reg <= pwdata[PORT_W-1:0];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmpIrq <= 1'b0;
         wakeReq <= 1'b0;
      end else begin
         cmpIrq <= flag_reg & ien_reg & periphEn_reg & globalEn_reg;
         wakeReq <= flag_reg & ien_reg & sleepMode;
      end
   end

   // unsynchronised result bypasses latch
   // unregistered on purpose: the pin must follow the comparator itself
   assign cmp1OutPin = anaSel.route ? (cmp1Raw ^ ctrl_reg.inv1) : portLatchOut[0];
   assign cmp2OutPin = anaSel.route ? (cmp2Raw ^ ctrl_reg.inv2) : portLatchOut[1];

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp1OutPinOe <= 1'b0;
         cmp2OutPinOe <= 1'b0;
      end else begin
         cmp1OutPinOe <= ~dir_reg[dcc_pkg::PIN1_IDX];
         cmp2OutPinOe <= ~dir_reg[dcc_pkg::PIN2_IDX];
      end
   end

   // read mux, sampled in the setup cycle
   always_comb begin
      rd_next = 32'h0;
      err_next = 1'b0;
      case (addrLo)
         dcc_pkg::OFS_CTRL: begin
            rd_next[7:0] = {outVal[1], outVal[0], ctrl_reg};
         end
         dcc_pkg::OFS_FLAG: begin
            rd_next[dcc_pkg::FLAG_BIT] = flag_reg;
         end
         dcc_pkg::OFS_IEN: begin
            rd_next[dcc_pkg::IEN_BIT] = ien_reg;
         end
         dcc_pkg::OFS_IRQCTL: begin
            rd_next[dcc_pkg::GLOBAL_EN_BIT] = globalEn_reg;
            rd_next[dcc_pkg::PERIPH_EN_BIT] = periphEn_reg;
         end
         dcc_pkg::OFS_PORT: begin
            rd_next[PORT_W-1:0] = portPinIn & ~analogPinMask;
         end
         dcc_pkg::OFS_DIR: begin
            rd_next[PORT_W-1:0] = dir_reg;
         end
         default: begin
            err_next = 1'b1;
         end
      endcase
   end

   // one wait-free access cycle after setup; data held from setup sample
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= setupPhase;
         if (setupPhase) begin
            pslverr <= err_next;
            prdata <= pwrite ? 32'h0 : rd_next;
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // checks
   property p_mode_off_reset;
      @(posedge sys_clk) $rose(arst_n)
         |-> ctrl_reg.mode == dcc_pkg::MODE_OFF && !ctrl_reg.inv2 && !ctrl_reg.inv1 && !ctrl_reg.inSwitch;
   endproperty
   a_mode_off_reset: assert property (p_mode_off_reset) else $error("control not at reset state");

   property p_ref_only_mux;
      @(posedge sys_clk) disable iff (!arst_n)
         (anaSel.pos1 == dcc_pkg::SEL_VREF) |-> $past(ctrl_reg.mode) == dcc_pkg::MODE_FOUR_MUX;
   endproperty
   a_ref_only_mux: assert property (p_ref_only_mux) else $error("reference used outside mode 110");

   property p_switch_route;
      @(posedge sys_clk) disable iff (!arst_n)
         (ctrl_reg.mode == dcc_pkg::MODE_FOUR_MUX && ctrl_reg.inSwitch) ##1 $stable(ctrl_reg)
            |-> anaSel.neg1 == dcc_pkg::SEL_AN3 && anaSel.neg2 == dcc_pkg::SEL_AN2;
   endproperty
   a_switch_route: assert property (p_switch_route) else $error("input switch not applied");

   property p_ro_bits;
      @(posedge sys_clk) disable iff (!arst_n)
         ctrlAcc && pwrite |=> ctrl_reg == $past(pwdata[5:0]);
   endproperty
   a_ro_bits: assert property (p_ro_bits) else $error("control write mishandled");

   property p_flag_on_change;
      @(posedge sys_clk) disable iff (!arst_n)
         mismatch && !ctrlAcc |=> flag_reg;
   endproperty
   a_flag_on_change: assert property (p_flag_on_change) else $error("flag not set on change");

   property p_sw_clear;
      @(posedge sys_clk) disable iff (!arst_n)
         doneAcc && pwrite && addrLo == dcc_pkg::OFS_FLAG && !flagSet |=> flag_reg == $past(pwdata[6]);
   endproperty
   a_sw_clear: assert property (p_sw_clear) else $error("flag write not honoured");

   property p_irq_gate;
      @(posedge sys_clk) disable iff (!arst_n)
         cmpIrq |-> $past(flag_reg) && $past(ien_reg) && $past(globalEn_reg) && $past(periphEn_reg);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without all enables");

   property p_irq_on;
      @(posedge sys_clk) disable iff (!arst_n)
         flag_reg && ien_reg && periphEn_reg && globalEn_reg |=> cmpIrq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt missing with all enables");

   property p_wake_gate;
      @(posedge sys_clk) disable iff (!arst_n)
         wakeReq |-> $past(flag_reg) && $past(ien_reg) && $past(sleepMode);
   endproperty
   a_wake_gate: assert property (p_wake_gate) else $error("wake without enabled flag in sleep");

   property p_mismatch_end;
      @(posedge sys_clk) disable iff (!arst_n)
         ctrlAcc ##1 $stable(sync2_reg) |-> !mismatch;
   endproperty
   a_mismatch_end: assert property (p_mismatch_end) else $error("access did not end mismatch");

   property p_read_polarity;
      @(posedge sys_clk) disable iff (!arst_n)
         setupPhase && !pwrite && addrLo == dcc_pkg::OFS_CTRL
            |=> prdata[7:6] == ($past(sync2_reg) ^ $past({ctrl_reg.inv2, ctrl_reg.inv1}));
   endproperty
   a_read_polarity: assert property (p_read_polarity) else $error("result bits wrong polarity");

   property p_port_analog;
      @(posedge sys_clk) disable iff (!arst_n)
         setupPhase && !pwrite && addrLo == dcc_pkg::OFS_PORT |=> (prdata[5:0] & $past(analogPinMask)) == 6'h0;
   endproperty
   a_port_analog: assert property (p_port_analog) else $error("analog pin read nonzero");

   property p_oe_dir;
      @(posedge sys_clk) disable iff (!arst_n)
         ##1 cmp1OutPinOe == !$past(dir_reg[4]);
   endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("pin enable does not follow direction");

   property p_oe2_dir;
      @(posedge sys_clk) disable iff (!arst_n)
         ##1 cmp2OutPinOe == !$past(dir_reg[5]);
   endproperty
   a_oe2_dir: assert property (p_oe2_dir) else $error("second pin enable does not follow direction");

   property p_sync_two;
      @(posedge sys_clk) disable iff (!arst_n)
         $changed(rawGated) ##1 $stable(rawGated) ##1 1'b1 |-> sync2_reg == $past(rawGated, 2);
   endproperty
   a_sync_two: assert property (p_sync_two) else $error("synchroniser latency wrong");

   c_flag_set: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(flag_reg));
   c_irq: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(cmpIrq));
   c_wake: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(wakeReq));
   c_route: cover property (@(posedge sys_clk) disable iff (!arst_n) anaSel.route && cmp1OutPinOe);
   c_ref_mux: cover property (@(posedge sys_clk) disable iff (!arst_n) anaSel.pos1 == dcc_pkg::SEL_VREF);
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end

module tb;
   logic sys_clk;
   logic arst_n;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cmp1Raw;
   logic cmp2Raw;
   logic sleepMode;
   logic [5:0] portPinIn;
   logic [5:0] analogPinMask;
   logic [1:0] portLatchOut;
   logic cmp1OutPin;
   logic cmp2OutPin;
   logic cmp1OutPinOe;
   logic cmp2OutPinOe;
   logic cmpIrq;
   logic wakeReq;
   dcc_pkg::dcc_sel_t anaSel;
   logic [31:0] rdData;
   logic errBit;
   int errors = 0;
   int samples_checked = 0;

   dcc_top #(.ADDR_W(8), .PORT_W(6)) dcc_top_i (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw), .portPinIn(portPinIn), .analogPinMask(analogPinMask),
      .portLatchOut(portLatchOut), .sleepMode(sleepMode), .cmp1OutPin(cmp1OutPin),
      .cmp2OutPin(cmp2OutPin), .cmp1OutPinOe(cmp1OutPinOe), .cmp2OutPinOe(cmp2OutPinOe),
      .anaSel(anaSel), .cmpIrq(cmpIrq), .wakeReq(wakeReq)
   );

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task test_done;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // entered just after a rising edge; one idle cycle after release
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         $display("[ERR] %0t no ready", $time);
         test_done();
      end
      rdData = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask

   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      cmp1Raw = 1'b0;
      cmp2Raw = 1'b0;
      sleepMode = 1'b0;
      portPinIn = 6'h00;
      analogPinMask = 6'h00;
      portLatchOut = 2'h0;
      tick(3);
      arst_n <= 1'b1;
      tick(1);
      `CHK(anaSel.cmpOn, 2'h0)
      rd(dcc_pkg::OFS_CTRL);
      `CHK(rdData, 32'h00000007)
      rd(dcc_pkg::OFS_DIR);
      `CHK(rdData, 32'h0000003f)
      rd(8'h20);
      `CHK(errBit, 1'b1)
      `CHK(rdData, 32'h00000000)
      $display("test reset done");
      for (int m = 0; m < 8; m++) begin
         wr(dcc_pkg::OFS_CTRL, 32'(m));
         rd(dcc_pkg::OFS_CTRL);
         `CHK(rdData[3:0], 4'(m))
         if (m != 6) `CHK({anaSel.pos1 == dcc_pkg::SEL_VREF, anaSel.pos2 == dcc_pkg::SEL_VREF}, 2'h0)
         if (m == 7) `CHK(anaSel.cmpOn, 2'h0)
         if (m == 2) `CHK(anaSel.cmpOn, 2'h3)
      end
      wr(dcc_pkg::OFS_CTRL, 32'h0000000e);
      tick(1);
      `CHK({anaSel.neg1, anaSel.neg2}, {dcc_pkg::SEL_AN3, dcc_pkg::SEL_AN2})
      `CHK({anaSel.pos1, anaSel.pos2}, {dcc_pkg::SEL_VREF, dcc_pkg::SEL_VREF})
      wr(dcc_pkg::OFS_CTRL, 32'h00000006);
      tick(1);
      `CHK({anaSel.neg1, anaSel.neg2}, {dcc_pkg::SEL_AN0, dcc_pkg::SEL_AN1})
      $display("test modes done");
      cmp1Raw <= 1'b1;
      tick(4);
      wr(dcc_pkg::OFS_CTRL, 32'h000000f2);
      rd(dcc_pkg::OFS_CTRL);
      `CHK(rdData, 32'h000000b2)
      wr(dcc_pkg::OFS_CTRL, 32'h00000002);
      rd(dcc_pkg::OFS_CTRL);
      `CHK(rdData, 32'h00000042)
      cmp1Raw <= 1'b0;
      cmp2Raw <= 1'b1;
      tick(4);
      rd(dcc_pkg::OFS_CTRL);
      `CHK(rdData, 32'h00000082)
      $display("test polarity done");
      wr(dcc_pkg::OFS_FLAG, 32'h00000000);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000000)
      cmp1Raw <= 1'b1;
      tick(5);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000040)
      wr(dcc_pkg::OFS_FLAG, 32'h00000000);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000040)
      rd(dcc_pkg::OFS_CTRL);
      wr(dcc_pkg::OFS_FLAG, 32'h00000000);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000000)
      wr(dcc_pkg::OFS_FLAG, 32'h00000040);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000040)
      $display("test flag done");
      for (int i = 0; i < 8; i++) begin
         wr(dcc_pkg::OFS_IEN, 32'(i & 1) << 6);
         wr(dcc_pkg::OFS_IRQCTL, 32'((i >> 1) & 3) << 6);
         tick(2);
         `CHK(cmpIrq, 1'(i == 7))
      end
      wr(dcc_pkg::OFS_IRQCTL, 32'h00000000);
      rd(dcc_pkg::OFS_FLAG);
      `CHK(rdData, 32'h00000040)
      sleepMode <= 1'b1;
      rd(dcc_pkg::OFS_CTRL);
      wr(dcc_pkg::OFS_FLAG, 32'h00000000);
      tick(2);
      `CHK(wakeReq, 1'b0)
      cmp2Raw <= 1'b0;
      tick(5);
      `CHK(wakeReq, 1'b1)
      rd(dcc_pkg::OFS_CTRL);
      `CHK(rdData, 32'h00000042)
      sleepMode <= 1'b0;
      tick(2);
      `CHK(wakeReq, 1'b0)
      $display("test irq done");
      portLatchOut <= 2'h1;
      wr(dcc_pkg::OFS_IEN, 32'h00000000);
      wr(dcc_pkg::OFS_CTRL, 32'h00000003);
      tick(1);
      `CHK({cmp2OutPin, cmp1OutPin}, 2'h1)
      cmp1Raw <= 1'b0;
      cmp2Raw <= 1'b1;
      #10;
      `CHK({cmp2OutPin, cmp1OutPin}, 2'h2)
      @(posedge sys_clk);
      wr(dcc_pkg::OFS_CTRL, 32'h00000033);
      `CHK({cmp2OutPin, cmp1OutPin}, 2'h1)
      wr(dcc_pkg::OFS_DIR, 32'h00000010);
      tick(1);
      `CHK({cmp2OutPinOe, cmp1OutPinOe}, 2'h2)
      wr(dcc_pkg::OFS_DIR, 32'h00000020);
      tick(1);
      `CHK({cmp2OutPinOe, cmp1OutPinOe}, 2'h1)
      wr(dcc_pkg::OFS_CTRL, 32'h00000002);
      tick(1);
      `CHK({cmp2OutPin, cmp1OutPin}, 2'h1)
      $display("test routing done");
      portPinIn <= 6'h3f;
      analogPinMask <= 6'h0f;
      tick(3);
      rd(dcc_pkg::OFS_PORT);
      `CHK(rdData, 32'h00000030)
      analogPinMask <= 6'h3f;
      tick(3);
      rd(dcc_pkg::OFS_PORT);
      `CHK(rdData, 32'h00000000)
      $display("test port done");
      // comparators off before sleep
      wr(dcc_pkg::OFS_CTRL, 32'h00000007);
      sleepMode <= 1'b1;
      tick(2);
      `CHK(anaSel.cmpOn, 2'h0)
      $display("test sleep off done");
      test_done();
   end
endmodule
